// ===== include/spf_map.svh
`ifndef SPF_MAP_SVH
`define SPF_MAP_SVH
// Register byte offsets on the APB port
`define SPF_CTRL_OFS    12'h000
`define SPF_LOCK_OFS    12'h004
`define SPF_FUSE_OFS    12'h008
`define SPF_ERASE_OFS   12'h00c
// Control register field positions
`define SPF_IE_BIT      7
`define SPF_BUSY_BIT    6
// Accepted low-five-bit command patterns
`define SPF_CMD_REEN    5'h11
`define SPF_CMD_PSET    5'h09
`define SPF_CMD_PWR     5'h05
`define SPF_CMD_PER     5'h03
`define SPF_CMD_LOAD    5'h01
// Reset values
`define SPF_CTRL_RESET  8'h00
`define SPF_LOCK_RESET  8'hff
`define SPF_BUF_RESET   16'hffff
// Arming windows in core cycles
`define SPF_ARM_CYCLES  3'd4
`define SPF_LPM_CYCLES  2'd3
// Programming time, rounded up to whole cycles
`define SPF_PROG_TIME_NS 3700000
`define SPF_CLK_PERIOD_NS 4
`define SPF_PROG_CYCLES ((`SPF_PROG_TIME_NS + `SPF_CLK_PERIOD_NS - 1) / `SPF_CLK_PERIOD_NS)
// First page of the no-read-while-write section
`define SPF_RWW_LIMIT_PAGE 7'd96
`endif

// ===== include/spf_pkg.sv
package spf_pkg;
  // Kind of long-running flash operation
  typedef enum logic [1:0] {
    SPF_OP_ERASE = 2'b00,
    SPF_OP_WRITE = 2'b01,
    SPF_OP_PROT  = 2'b10
  } spf_op_t;
endpackage

// ===== hdl/spf_ctrl.sv
// Overview of operation
// [RULE1] Ready interrupt requested while enable bit clear
// [RULE2] Erase/write to section sets busy, blocks
// [RULE3] Busy clears on re-enable or buffer load
// [RULE4] Reserved control bit reads zero always
// [RULE5] Re-enable armed, store within four cycles
// [RULE6] Re-enable refused while operation still running
// [RULE7] Re-enable during loading clears page buffer
// [RULE8] Protection set programs bits from low data
// [RULE9] Protection-set bit clears when done or timeout
// [RULE10] Load within three cycles reads lock/fuse
// [RULE11] Page write copies buffer into pointer page
// [RULE12] Write bit self-clears; core stalled in boot
// [RULE13] Page erase clears page at pointer
// [RULE14] Erase bit self-clears when done or timeout
// [RULE15] Plain enable loads data pair into buffer
// [RULE16] Enable clears after store or four cycles
// [RULE17] Only five command patterns have any effect
// [RULE18] Protection bits return high only by erase
// [RULE19] General lock bits block external access
// [RULE20] Application pair blocks writes and reads
// [RULE21] Boot pair blocks writes and reads
// [RULE22] Read-blocking modes suppress cross-section interrupts
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "spf_map.svh"
module spf_ctrl
  import spf_pkg::*;
#(
  parameter int         PROG_CYCLES     = `SPF_PROG_CYCLES,
  parameter logic [6:0] BOOT_START_PAGE = 7'd96
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gie,
  input  wire logic        spm_req,
  input  wire logic [15:0] spm_ptr,
  input  wire logic [15:0] spm_data,
  output logic             spm_done,
  input  wire logic        lpm_req,
  input  wire logic [15:0] lpm_ptr,
  output logic      [7:0]  lpm_data,
  output logic             lpm_valid,
  output logic             lpm_blocked,
  input  wire logic        pc_in_boot,
  input  wire logic        vec_in_boot,
  input  wire logic [7:0]  fuse_low,
  input  wire logic [7:0]  fuse_high,
  output logic             ready_irq,
  output logic             core_stall,
  output logic             rww_blocked,
  output logic             irq_suppress,
  output logic             ext_prog_block,
  output logic             ext_verify_block,
  output logic             fuse_frozen
);

  // Counter must reach the full programming time; width follows it
  localparam int RW = $clog2(PROG_CYCLES + 1);

  // Flash array and temporary page buffer
  // Array is 128 pages of 32 words, indexed {page, word}
  // Buffer words read as erased until loaded
  logic [15:0] flash_mem [0:4095];
  logic [15:0] page_buf  [0:31];

  // Control register state
  logic          ready_irq_enable;   // Software interrupt enable
  logic          section_busy_flag;  // Set by hardware
  logic [4:0]    cmd;                // Low five control bits
  logic [2:0]    arm_cnt;            // Store window countdown
  logic [1:0]    lpm_win;            // Lock read window
  // Long operation state
  logic          running;            // Erase/write/lock busy
  logic [RW-1:0] run_cnt;            // Cycles left
  spf_op_t       op_kind;            // What to do at the end
  logic [6:0]    op_page;            // Target page
  logic [5:0]    op_bits;            // Lock data latched
  logic          buf_loaded;         // Buffer holds new data
  logic          abort_pend;         // Buffer to be discarded
  logic [7:0]    lock;               // Lock byte, 0 = programmed

  // Bus decode
  logic        acc;
  logic        wr_ctrl;
  logic        wr_erase;
  logic        mapped;
  logic        pat_ok;
  logic        cmd_accept;
  // Store decode
  logic        armed;
  logic        spm_go;
  logic [6:0]  tgt_page;
  logic        tgt_boot;
  logic        tgt_rww;
  logic        wr_blocked;
  logic        do_load;
  logic        do_reen;
  logic        do_pset;
  logic        do_prog;
  logic        finish;
  // Load decode
  logic [6:0]  rd_page;
  logic        rd_boot;
  logic        rd_block;

  // Zero wait states, so the access phase is one cycle
  // APB access phase and register hits
  assign acc      = psel & penable;
  assign wr_ctrl  = acc & pwrite & (paddr == `SPF_CTRL_OFS);
  assign wr_erase = acc & pwrite & (paddr == `SPF_ERASE_OFS);
  assign mapped   = (paddr == `SPF_CTRL_OFS) | (paddr == `SPF_LOCK_OFS)
                  | (paddr == `SPF_FUSE_OFS) | (paddr == `SPF_ERASE_OFS);

  // Any other pattern is dropped whole, interrupt enable excepted
  // [RULE17] Pattern filter
  assign pat_ok = (pwdata[4:0] == `SPF_CMD_REEN) | (pwdata[4:0] == `SPF_CMD_PSET)
                | (pwdata[4:0] == `SPF_CMD_PWR)  | (pwdata[4:0] == `SPF_CMD_PER)
                | (pwdata[4:0] == `SPF_CMD_LOAD);
  // Refusing here keeps a running operation's command intact
  // [RULE6] No commands while busy
  assign cmd_accept = wr_ctrl & pat_ok & ~running;

  // Window counts edges after the accepting write
  // A store counts only inside the arming window
  assign armed  = (arm_cnt != 3'd0) & ~running;
  assign spm_go = spm_req & armed;

  // Pointer bits above 12 are ignored, bit 0 as well
  // Page and section of the store target
  assign tgt_page = spm_ptr[12:6];
  assign tgt_boot = tgt_page >= BOOT_START_PAGE;
  assign tgt_rww  = tgt_page < `SPF_RWW_LIMIT_PAGE;
  // A blocked erase or write still ends the store
  // [RULE20] [RULE21] Write blocking
  assign wr_blocked = tgt_boot ? ~lock[4] : ~lock[2];

  // Run counter reaches zero on the last busy cycle
  // Decoded store actions
  assign do_load = spm_go & (cmd == `SPF_CMD_LOAD);
  assign do_reen = spm_go & (cmd == `SPF_CMD_REEN);
  assign do_pset = spm_go & (cmd == `SPF_CMD_PSET);
  assign do_prog = spm_go & ~wr_blocked
                 & ((cmd == `SPF_CMD_PWR) | (cmd == `SPF_CMD_PER));
  assign finish  = running & (run_cnt == '0);

  // One process, so set and clear of a bit never race
  // Priority: running op, new command, store, window
  // Control register and sequencing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ready_irq_enable  <= 1'b0;
      section_busy_flag <= 1'b0;
      cmd               <= 5'h00;
      arm_cnt           <= 3'd0;
      lpm_win           <= 2'd0;
      running           <= 1'b0;
      run_cnt           <= '0;
      op_kind           <= SPF_OP_ERASE;
      op_page           <= 7'd0;
      op_bits           <= 6'h3f;
      core_stall        <= 1'b0;
      buf_loaded        <= 1'b0;
      abort_pend        <= 1'b0;
      // Lock byte and buffer reset in their own processes
    end else begin
      // Interrupt enable stays writable at all times
      if (wr_ctrl) begin
        ready_irq_enable <= pwdata[`SPF_IE_BIT];
      end
      if (running) begin
        // [RULE12] [RULE14] [RULE16] Clear at completion
        if (finish) begin
          running    <= 1'b0;
          cmd        <= 5'h00;
          core_stall <= 1'b0;
        end else begin
          // Commands are refused meanwhile
          run_cnt <= run_cnt - 1'b1;
        end
      end else if (cmd_accept) begin
        // New command; a fresh write restarts the window
        cmd     <= pwdata[4:0];
        arm_cnt <= `SPF_ARM_CYCLES;
        // [RULE10] Lock read window opens
        lpm_win <= (pwdata[4:0] == `SPF_CMD_PSET) ? `SPF_LPM_CYCLES : 2'd0;
        // [RULE7] Re-enable during loading aborts it
        if ((pwdata[4:0] == `SPF_CMD_REEN) && buf_loaded) begin
          abort_pend <= 1'b1;
          buf_loaded <= 1'b0;
        end
      end else if (spm_go) begin
        // Store inside the window; one per arming
        arm_cnt <= 3'd0;
        lpm_win <= 2'd0;
        if (do_prog) begin
          // [RULE11] [RULE13] Start erase or write
          running <= 1'b1;
          run_cnt <= RW'(PROG_CYCLES - 1);
          op_kind <= (cmd == `SPF_CMD_PWR) ? SPF_OP_WRITE : SPF_OP_ERASE;
          op_page <= tgt_page;
          if (tgt_rww) begin
            // [RULE2] Section goes busy
            section_busy_flag <= 1'b1;
          end else begin
            // [RULE12] Core waits on own section
            core_stall <= 1'b1;
          end
        end else if (do_pset) begin
          // [RULE8] Latch lock data, pointer unused
          running <= 1'b1;
          run_cnt <= RW'(PROG_CYCLES - 1);
          op_kind <= SPF_OP_PROT;
          op_bits <= spm_data[5:0];
        end else begin
          // [RULE16] Enable clears after the store
          cmd <= 5'h00;
        end
        if (do_load) begin
          // [RULE3] Buffer load frees section
          section_busy_flag <= 1'b0;
          buf_loaded        <= 1'b1;
        end
        if (do_reen) begin
          // [RULE5] Section readable again
          section_busy_flag <= 1'b0;
          abort_pend        <= 1'b0;
        end
      end else if (arm_cnt != 3'd0) begin
        // Enable bit and command drop together at expiry
        // [RULE9] [RULE14] [RULE16] Window expiry
        arm_cnt <= arm_cnt - 3'd1;
        if (arm_cnt == 3'd1) begin
          cmd <= 5'h00;
        end
        if (lpm_win != 2'd0) begin
          lpm_win <= lpm_win - 2'd1;
        end
      end
    end
  end

  // Never two cycles long: the window closes on the store
  // Store completion pulse, immediate or at end of run
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      spm_done <= 1'b0;
    end else begin
      spm_done <= (spm_go & ~do_prog & ~do_pset) | finish;
    end
  end

  // Clearing all words at once costs area, saves a sweep
  // Temporary page buffer
  always_ff @(posedge ref_clk) begin
    if (srst || (do_reen && abort_pend)) begin
      // [RULE7] Discard the partial page
      for (int i = 0; i < 32; i++) begin
        page_buf[i] <= `SPF_BUF_RESET;
      end
    end else if (do_load) begin
      // [RULE15] Word by pointer, byte bit ignored
      page_buf[spm_ptr[5:1]] <= spm_data;
    end
  end

  // Whole page lands at the end of the run
  // Flash page programming; array has no reset
  always_ff @(posedge ref_clk) begin
    if (finish && (op_kind == SPF_OP_ERASE)) begin
      // [RULE13] Erase whole page
      for (int i = 0; i < 32; i++) begin
        flash_mem[{op_page, i[4:0]}] <= `SPF_BUF_RESET;
      end
    end else if (finish && (op_kind == SPF_OP_WRITE)) begin
      // [RULE11] Copy buffer into page
      for (int i = 0; i < 32; i++) begin
        flash_mem[{op_page, i[4:0]}] <= page_buf[i];
      end
    end
  end

  // Bits 7 and 6 have no function and read as one
  // Lock byte; top two bits stay unprogrammed
  always_ff @(posedge ref_clk) begin
    if (srst || wr_erase) begin
      // [RULE18] Only erase raises bits
      lock <= `SPF_LOCK_RESET;
    end else if (finish && (op_kind == SPF_OP_PROT)) begin
      // [RULE8] [RULE18] Bits can only be programmed
      lock <= {2'b11, lock[5:0] & op_bits};
    end
  end

  // Busy section reads as erased instead of stale data
  // Load source and target sections
  assign rd_page = lpm_ptr[12:6];
  assign rd_boot = rd_page >= BOOT_START_PAGE;
  // [RULE2] [RULE20] [RULE21] Read blocking
  assign rd_block = (section_busy_flag & (rd_page < `SPF_RWW_LIMIT_PAGE))
                  | (pc_in_boot & ~rd_boot & ~lock[3])
                  | (~pc_in_boot & rd_boot & ~lock[5]);

  // Lock read wins over blocking: it never touches the array
  // Load answer, one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lpm_valid   <= 1'b0;
      lpm_blocked <= 1'b0;
      lpm_data    <= 8'h00;
    end else begin
      lpm_valid   <= lpm_req;
      lpm_blocked <= 1'b0;
      if (lpm_req) begin
        if ((lpm_win != 2'd0) && (cmd == `SPF_CMD_PSET)) begin
          // [RULE10] Byte bit picks lock or fuse
          lpm_data <= lpm_ptr[0] ? fuse_low : lock;
        end else if (rd_block) begin
          // Blocked reads return erased value
          lpm_data    <= 8'hff;
          lpm_blocked <= 1'b1;
        end else if (lpm_ptr[0]) begin
          lpm_data <= flash_mem[lpm_ptr[12:1]][15:8];
        end else begin
          lpm_data <= flash_mem[lpm_ptr[12:1]][7:0];
        end
      end
    end
  end

  // Captured one edge early, so it stands at the access edge
  // Limitation: a change in the setup cycle shows on the next read
  // APB read data captured in the setup phase
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        // [RULE4] Reserved bit reads zero
        `SPF_CTRL_OFS: prdata <= {24'h0, ready_irq_enable, section_busy_flag, 1'b0, cmd};
        `SPF_LOCK_OFS: prdata <= {24'h0, lock};
        `SPF_FUSE_OFS: prdata <= {16'h0, fuse_high, fuse_low};
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait slave; unmapped access flags an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // Suppression covers only the read-blocking modes
  // [RULE22] Interrupt suppression
  assign irq_suppress = (vec_in_boot & ~pc_in_boot & ~lock[3])
                      | (~vec_in_boot & pc_in_boot & ~lock[5]);
  // Level, not pulse: held while no command is armed or running
  // [RULE1] Ready interrupt level
  assign ready_irq = ready_irq_enable & gie & ~cmd[0] & ~irq_suppress;
  // Fetches from the busy section wait for re-enable or a buffer load
  // [RULE2] Section fetch blocking
  assign rww_blocked = section_busy_flag;
  // External port logic sits elsewhere; only levels here
  // [RULE19] External programming locks
  assign ext_prog_block   = ~lock[0];
  assign fuse_frozen      = ~lock[0];
  assign ext_verify_block = ~lock[0] & ~lock[1];

endmodule
`default_nettype wire

// ===== test/spf_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// Behavioural core issuing store and load program requests
module spf_core_model (
  input  wire logic        ref_clk,
  output logic             spm_req = 1'b0,
  output logic      [15:0] spm_ptr = 16'h0000,
  output logic      [15:0] spm_data = 16'h0000,
  output logic             lpm_req = 1'b0,
  output logic      [15:0] lpm_ptr = 16'h0000,
  input  wire logic [7:0]  lpm_data
);
  // one store per arming, inside window
  task automatic spm(input logic [15:0] p, input logic [15:0] v);
    @(posedge ref_clk);
    spm_req  <= 1'b1;
    spm_ptr  <= p;
    spm_data <= v;
    @(posedge ref_clk);
    spm_req  <= 1'b0;
    // Released lines flip so stale values never match
    spm_ptr  <= ~p;
    spm_data <= ~v;
  endtask
  // Load request; answer taken at the edge where it stands
  task automatic lpm(input logic [15:0] p, output logic [7:0] r);
    @(posedge ref_clk);
    lpm_req <= 1'b1;
    lpm_ptr <= p;
    @(posedge ref_clk);
    lpm_req <= 1'b0;
    lpm_ptr <= ~p;
    @(posedge ref_clk);
    r = lpm_data;
  endtask
endmodule
`default_nettype wire

// ===== test/spf_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks on the flash sequencer
module spf_ctrl_monitor #(
  parameter logic [6:0] BOOT_START_PAGE = 7'd96
) (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        gie,
  input wire logic        spm_req,
  input wire logic [15:0] spm_ptr,
  input wire logic        spm_done,
  input wire logic        lpm_req,
  input wire logic [7:0]  lpm_data,
  input wire logic        lpm_valid,
  input wire logic        lpm_blocked,
  input wire logic        pc_in_boot,
  input wire logic        vec_in_boot,
  input wire logic        ready_irq,
  input wire logic        core_stall,
  input wire logic        rww_blocked,
  input wire logic        irq_suppress
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  a_irq_gie: assert property (ready_irq |-> gie)
    else $error("irq without gie");
  a_busy_set: assert property ($rose(rww_blocked) |-> $past(spm_req))
    else $error("busy set without store");
  a_busy_clr: assert property ($fell(rww_blocked) |-> $past(spm_req) || $past(srst))
    else $error("busy cleared without store");
  a_stall_from: assert property ($rose(core_stall) |->
    $past(spm_req) && $past(spm_ptr[12:6]) >= BOOT_START_PAGE)
    else $error("stall without boot target");
  a_lpm_answer: assert property (lpm_req |=> lpm_valid)
    else $error("load not answered");
  a_blocked_ff: assert property (lpm_blocked |-> lpm_valid && lpm_data == 8'hff)
    else $error("blocked read leaks data");
  a_suppress_irq: assert property (irq_suppress |->
    !ready_irq && pc_in_boot != vec_in_boot)
    else $error("suppress wrong");
  a_done_pulse: assert property (spm_done |=> !spm_done)
    else $error("done longer than a cycle");
  c_busy: cover property ($rose(rww_blocked));
  c_stall: cover property ($rose(core_stall));
  c_blocked: cover property (lpm_blocked);
endmodule
bind spf_ctrl spf_ctrl_monitor #(.BOOT_START_PAGE(BOOT_START_PAGE)) u_mon (
  .ref_clk, .srst, .gie, .spm_req, .spm_ptr, .spm_done, .lpm_req, .lpm_data, .lpm_valid,
  .lpm_blocked, .pc_in_boot, .vec_in_boot, .ready_irq, .core_stall, .rww_blocked, .irq_suppress
);
`default_nettype wire

// ===== test/test_self_program_flash_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "spf_map.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, x); end end
module test_self_program_flash_control;
  logic        ref_clk = 1'b0, srst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        gie = 1'b0, pc_in_boot = 1'b1, vec_in_boot = 1'b0;
  logic [7:0]  fuse_low = 8'h00, fuse_high = 8'h00, lpm_data, b;
  logic        pready, pslverr, e, spm_req, spm_done, lpm_req, lpm_valid, lpm_blocked;
  logic        ready_irq, core_stall, rww_blocked, irq_suppress;
  logic        ext_prog_block, ext_verify_block, fuse_frozen;
  logic [15:0] spm_ptr, spm_data, lpm_ptr, d;
  logic [4:0]  w, p;
  int          num_errors = 0, compares = 0;
  // 4 ns period
  always #2 ref_clk = ~ref_clk;
  // Short programming time keeps the run brief
  spf_ctrl #(.PROG_CYCLES(8)) dut (
    .ref_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .gie, .spm_req, .spm_ptr, .spm_data, .spm_done, .lpm_req, .lpm_ptr,
    .lpm_data, .lpm_valid, .lpm_blocked, .pc_in_boot, .vec_in_boot, .fuse_low,
    .fuse_high, .ready_irq, .core_stall, .rww_blocked, .irq_suppress,
    .ext_prog_block, .ext_verify_block, .fuse_frozen
  );
  spf_core_model core (
    .ref_clk, .spm_req, .spm_ptr, .spm_data, .lpm_req, .lpm_ptr, .lpm_data
  );
  // Verdict and end of run
  task automatic summarize();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // One APB transfer, pready awaited under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask
  // Command write, interrupt enable kept set
  task automatic wc(input logic [4:0] c);
    apb(1'b1, `SPF_CTRL_OFS, {24'h0, 3'b100, c});
  endtask
  // Completion pulse, bounded wait
  task automatic wdone();
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (spm_done !== 1'b1 && n < 64);
    if (n >= 64) begin
      num_errors++;
      summarize();
    end
  endtask
  function automatic logic [31:0] cx(input logic busy, input logic [4:0] c);
    return {24'h0, 1'b1, busy, 1'b0, c};
  endfunction
  function automatic logic [15:0] zp(input logic [6:0] pg, input logic [4:0] wd, input logic hi);
    return {3'b000, pg, wd, hi};
  endfunction
  initial begin
    void'($urandom(32'h7cf99df2));
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    fuse_low <= 8'($urandom);
    fuse_high <= 8'($urandom);
    rdc(`SPF_CTRL_OFS, 32'h0);
    rdc(`SPF_LOCK_OFS, 32'hff);
    rdc(`SPF_FUSE_OFS, {16'h0, fuse_high, fuse_low});
    rdc(12'h010, 32'h0);
    `CHK(e, 1'b1)
    // Invalid patterns change only the interrupt enable; bit 5 stays zero
    repeat (4) begin
      p = 5'($urandom);
      if (p inside {`SPF_CMD_REEN, `SPF_CMD_PSET, `SPF_CMD_PWR,
                    `SPF_CMD_PER, `SPF_CMD_LOAD}) begin
        p = 5'h1f;
      end
      apb(1'b1, `SPF_CTRL_OFS, {24'h0, 3'b111, p});
      rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h00));
    end
    apb(1'b1, `SPF_CTRL_OFS, 32'ha1);
    rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h01));
    repeat (5) @(posedge ref_clk);
    rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h00));
    gie <= 1'b1;
    @(posedge ref_clk);
    #1 `CHK(ready_irq, 1'b1)
    $display("control test done");
    // Load a word, write it to a boot page
    w = 5'($urandom);
    d = 16'($urandom);
    wc(`SPF_CMD_LOAD);
    core.spm(zp(7'd0, w, 1'b1), d);
    rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h00));
    wc(`SPF_CMD_PWR);
    core.spm(zp(7'd100, 5'd0, 1'b0), 16'($urandom));
    #1 `CHK(core_stall, 1'b1)
    wdone();
    rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h00));
    core.lpm(zp(7'd100, w, 1'b0), b);
    `CHK(b, d[7:0])
    core.lpm(zp(7'd100, w, 1'b1), b);
    `CHK(b, d[15:8])
    core.lpm(zp(7'd100, 5'(w + 5'd1), 1'b0), b);
    `CHK(b, 8'hff)
    $display("page write test done");
    // Erase an application page; re-enable refused meanwhile
    wc(`SPF_CMD_PER);
    core.spm(zp(7'd5, 5'd0, 1'b0), 16'($urandom));
    #1 `CHK(rww_blocked, 1'b1)
    wc(`SPF_CMD_REEN);
    `CHK(ready_irq, 1'b0)
    rdc(`SPF_CTRL_OFS, cx(1'b1, `SPF_CMD_PER));
    wdone();
    rdc(`SPF_CTRL_OFS, cx(1'b1, 5'h00));
    wc(`SPF_CMD_LOAD);
    core.spm(zp(7'd0, w, 1'b0), d);
    rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h00));
    core.lpm(zp(7'd5, w, 1'b1), b);
    `CHK(b, 8'hff)
    // Re-enable while loaded drops the buffer
    wc(`SPF_CMD_REEN);
    core.spm(16'h0000, 16'h0000);
    wdone();
    wc(`SPF_CMD_PWR);
    core.spm(zp(7'd6, 5'd0, 1'b0), 16'h0000);
    wdone();
    `CHK(rww_blocked, 1'b1)
    wc(`SPF_CMD_REEN);
    core.spm(16'h0000, 16'h0000);
    wdone();
    #1 `CHK(rww_blocked, 1'b0)
    core.lpm(zp(7'd6, w, 1'b0), b);
    `CHK(b, 8'hff)
    $display("erase test done");
    // Protection bits from the low byte only
    wc(`SPF_CMD_PSET);
    core.spm(16'($urandom), {8'($urandom), 8'hf3});
    wdone();
    rdc(`SPF_LOCK_OFS, 32'hf3);
    rdc(`SPF_CTRL_OFS, cx(1'b0, 5'h00));
    wc(`SPF_CMD_PSET);
    core.lpm(16'h0000, b);
    `CHK(b, 8'hf3)
    wc(`SPF_CMD_PSET);
    core.lpm(16'h0001, b);
    `CHK(b, fuse_low)
    wc(`SPF_CMD_PSET);
    core.spm(16'h0000, 16'h00ff);
    wdone();
    rdc(`SPF_LOCK_OFS, 32'hf3);
    `CHK(ext_prog_block, 1'b0)
    core.lpm(zp(7'd0, w, 1'b0), b);
    `CHK(lpm_blocked, 1'b1)
    wc(`SPF_CMD_PER);
    core.spm(zp(7'd2, 5'd0, 1'b0), 16'h0000);
    wdone();
    #1 `CHK(rww_blocked, 1'b0)
    // General lock bits, first one then both
    wc(`SPF_CMD_PSET);
    core.spm(16'h0000, 16'h00fe);
    wdone();
    `CHK({ext_prog_block, fuse_frozen, ext_verify_block}, 3'b110)
    wc(`SPF_CMD_PSET);
    core.spm(16'h0000, 16'h00fd);
    wdone();
    `CHK({ext_prog_block, fuse_frozen, ext_verify_block}, 3'b111)
    pc_in_boot <= 1'b0;
    vec_in_boot <= 1'b1;
    @(posedge ref_clk);
    #1 `CHK(irq_suppress, 1'b1)
    apb(1'b1, `SPF_ERASE_OFS, $urandom);
    rdc(`SPF_LOCK_OFS, 32'hff);
    `CHK({ext_prog_block, fuse_frozen, ext_verify_block}, 3'b000)
    `CHK(irq_suppress, 1'b0)
    $display("protection test done");
    summarize();
  end
endmodule
`default_nettype wire
